// ### verilog/card_register_set.sv
// Card register set: conditions word, identity and specific data
// Assumes commands and program bits arrive decoded and synchronous
`include "card_regs_defines.svh"
module card_register_set #(
  parameter logic         DUAL_VOLTAGE   = 1'b1,
  // Arbitrary neutral identity values
  parameter logic [7:0]   MAKER_CODE     = 8'h5A,
  parameter logic [15:0]  OEM_CODE       = 16'h0000,
  parameter logic [47:0]  PRODUCT_NAME   = 48'h434152443031,
  parameter logic [7:0]   PRODUCT_REV    = 8'h10,
  parameter logic [7:0]   MAKE_DATE      = 8'h10,
  parameter logic [11:0]  DEVICE_SIZE    = 12'hFFF,
  parameter logic [2:0]   SIZE_MULT      = 3'h7,
  parameter logic [2:0]   CURR_MAX       = 3'h6,
  parameter logic [14:0]  GROUP_SIZES    = 15'h0000,
  parameter logic [2:0]   WRITE_FACTOR   = 3'h0,
  parameter logic         CONTENT_PROT   = 1'b0,
  parameter int unsigned  POWERUP_CYCLES =
    (`POWERUP_TIME_US * 1000 + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       resetn,
  input  wire logic                       clk_en,
  // Decoded command and program bits
  input  wire card_regs_pkg::cmd_req_type  cmd,
  input  wire card_regs_pkg::prog_bit_type prog,
  // Identity strap
  input  wire logic [31:0]                serial_strap,
  // Open-drain or push-pull response line
  input  wire logic                       line_in,
  output logic                            line_out,
  output logic                            line_oe,
  // Status
  output logic                            power_ready,
  output logic                            prog_done,
  output logic                            prog_error
);
  card_regs_pkg::regs_state_type st;
  card_regs_pkg::regs_state_type nxt;
  logic [31:0]                   cond_word;
  logic [119:0]                  ident_body;
  logic [6:0]                    ident_crc;
  logic [127:0]                  ident_word;
  logic [127:0]                  spec_word;
  logic                          take_cmd;
  logic                          start;
  logic [127:0]                  ld_word;
  logic [7:0]                    ld_len;
  logic                          ld_od;
  logic                          tx_active;
  logic                          tx_lost;
  logic                          in_commit;
  logic                          spec_msb;

  function automatic logic responds(input logic [5:0] idx,
                                    input logic       rdy);
    logic any_ready;
    any_ready = (idx == `CMD_ALL_IDENTITY) || (idx == `CMD_READ_SPECIFIC) ||
                (idx == `CMD_READ_IDENTITY) ||
                (idx == `CMD_PROGRAM_SPECIFIC);
    return (idx == `CMD_READ_CONDITIONS) || (rdy && any_ready);
  endfunction : responds

  function automatic logic ro_bad(input logic [127:0] rx,
                                  input logic [127:0] cur);
    logic [127:0] d;
    d = rx ^ cur;
    d[121:120] = 2'h0;
    d[75:74] = 2'h0;
    d[20:17] = 4'h0;
    return |d[127:16];
  endfunction : ro_bad

  // Conditions word
  assign cond_word = {st.ready, 7'h00, `COND_VOLT_RANGE, 7'h00,
                      DUAL_VOLTAGE, 7'h00};

  // Identity word
  assign ident_body = {MAKER_CODE, OEM_CODE, PRODUCT_NAME, PRODUCT_REV,
                       st.serial, MAKE_DATE};

  card_crc7 u_crc (
    .data (ident_body),
    .crc  (ident_crc)
  );

  assign ident_word = {ident_body, ident_crc, 1'b1};

  // Specific data word
  assign spec_word = {`SPEC_STRUCTURE_VAL, `SPEC_VERSION_VAL,
                      2'h0, `SPEC_ACCESS_TIME, `SPEC_CLOCK_ACCESS,
                      `SPEC_TRAN_SPEED, `SPEC_CLASSES, `SPEC_BLOCK_LEN,
                      4'h0, 2'h0, DEVICE_SIZE, `SPEC_CURR_MIN, CURR_MAX,
                      `SPEC_CURR_MIN, CURR_MAX, SIZE_MULT, GROUP_SIZES,
                      1'b1, 2'h0, WRITE_FACTOR, `SPEC_BLOCK_LEN, 1'b0,
                      4'h0, CONTENT_PROT, st.prog[15:1],
                      1'b1};

  assign take_cmd = clk_en && (st.phase == card_regs_pkg::PH_IDLE) &&
                    cmd.valid && responds(cmd.index, st.ready);
  assign in_commit = (st.phase == card_regs_pkg::PH_COMMIT);
  assign spec_msb = spec_word[127];

  always_comb
  begin
    nxt = st;
    start = 1'b0;
    ld_word = '0;
    ld_len = 8'h00;
    ld_od = 1'b0;
    if (clk_en)
    begin
      nxt.prog_done = 1'b0;
      if (!st.strap_taken)
      begin
        nxt.serial = serial_strap;
        nxt.strap_taken = 1'b1;
      end
      if (!st.ready)
      begin
        if (st.pcnt == 16'(POWERUP_CYCLES - 1))
          nxt.ready = 1'b1;
        else
          nxt.pcnt = st.pcnt + 16'h0001;
      end
      case (st.phase)
        card_regs_pkg::PH_IDLE:
        begin
          if (take_cmd)
          begin
            case (cmd.index)
              `CMD_READ_CONDITIONS:
              begin
                start = 1'b1;
                ld_word = {cond_word, 96'h0};
                ld_len = `COND_BITS;
                ld_od = 1'b1;
              end
              `CMD_ALL_IDENTITY:
              begin
                start = 1'b1;
                ld_word = ident_word;
                ld_len = `WORD_BITS;
                ld_od = 1'b1;
              end
              `CMD_READ_IDENTITY:
              begin
                start = 1'b1;
                ld_word = ident_word;
                ld_len = `WORD_BITS;
              end
              `CMD_READ_SPECIFIC:
              begin
                start = 1'b1;
                ld_word = spec_word;
                ld_len = `WORD_BITS;
              end
              default:
              begin
                nxt.rx_cnt = 8'h00;
                nxt.prog_error = 1'b0;
              end
            endcase
            nxt.phase = start ? card_regs_pkg::PH_SEND :
                                card_regs_pkg::PH_RECV;
          end
        end
        card_regs_pkg::PH_SEND:
        begin
          if (!tx_active)
            nxt.phase = card_regs_pkg::PH_IDLE;
        end
        card_regs_pkg::PH_RECV:
        begin
          if (prog.valid)
          begin
            nxt.rx = {st.rx[126:0], prog.data};
            nxt.rx_cnt = st.rx_cnt + 8'h01;
            if (st.rx_cnt == `LAST_RX_BIT)
              nxt.phase = card_regs_pkg::PH_COMMIT;
          end
        end
        card_regs_pkg::PH_COMMIT:
        begin
          nxt.phase = card_regs_pkg::PH_IDLE;
          nxt.prog_done = 1'b1;
          if (ro_bad(st.rx, spec_word))
            nxt.prog_error = 1'b1;
          else
          begin
            if (!st.locked[3])
            begin
              nxt.prog[`SPEC_FMT_GRP_BIT] = st.rx[`SPEC_FMT_GRP_BIT];
              nxt.locked[3] = 1'b1;
            end
            if (!st.locked[2])
            begin
              nxt.prog[`SPEC_COPY_BIT] = st.rx[`SPEC_COPY_BIT];
              nxt.locked[2] = 1'b1;
            end
            if (!st.locked[1])
            begin
              nxt.prog[`SPEC_PERM_BIT] = st.rx[`SPEC_PERM_BIT];
              nxt.locked[1] = 1'b1;
            end
            if (!st.locked[0])
            begin
              nxt.prog[11:10] = st.rx[11:10];
              nxt.locked[0] = 1'b1;
            end
            nxt.prog[`SPEC_TMP_BIT] = st.rx[`SPEC_TMP_BIT];
            nxt.prog[9:1] = st.rx[9:1];
            nxt.prog[0] = 1'b1;
          end
        end
        default:
        begin
          nxt.phase = card_regs_pkg::PH_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st <= '0;
      st.prog <= `SPEC_PROG_RESET;
    end
    else
      st <= nxt;
  end

  card_shifter u_shift (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .clk_en   (clk_en),
    .start    (start),
    .word     (ld_word),
    .len      (ld_len),
    .od       (ld_od),
    .line_in  (line_in),
    .line_out (line_out),
    .line_oe  (line_oe),
    .active   (tx_active),
    .lost     (tx_lost)
  );

  assign power_ready = st.ready;
  assign prog_done   = st.prog_done;
  assign prog_error  = st.prog_error;

  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  property p_cond_reserved;
    cond_word[6:0] == 7'h00 && cond_word[14:8] == 7'h00 &&
    cond_word[30:24] == 7'h00;
  endproperty
  a_cond_reserved: assert property (p_cond_reserved)
    else $error("reserved conditions bits not zero");

  property p_cond_volt;
    cond_word[23:15] == 9'h1FF && cond_word[7] == DUAL_VOLTAGE;
  endproperty
  a_cond_volt: assert property (p_cond_volt)
    else $error("voltage window bits wrong");

  property p_ready_time;
    $rose(power_ready) |-> $past(st.pcnt) == 16'(POWERUP_CYCLES - 1);
  endproperty
  a_ready_time: assert property (p_ready_time)
    else $error("power-up finished at wrong count");

  property p_busy_low;
    (take_cmd && cmd.index == `CMD_READ_CONDITIONS && !st.ready)
      |=> (line_oe && !line_out);
  endproperty
  a_busy_low: assert property (p_busy_low)
    else $error("busy card did not pull the line low");

  property p_answer_cause;
    $rose(tx_active) |-> $past(take_cmd);
  endproperty
  a_answer_cause: assert property (p_answer_cause)
    else $error("response without a command");

  property p_ident_fixed;
    ident_word[127:120] == MAKER_CODE && ident_word[0] &&
    ident_word[119:104] == OEM_CODE;
  endproperty
  a_ident_fixed: assert property (p_ident_fixed)
    else $error("identity fixed fields wrong");

  property p_serial_held;
    st.strap_taken |=> $stable(ident_word[47:16]);
  endproperty
  a_serial_held: assert property (p_serial_held)
    else $error("serial number changed");

  property p_prog_only_commit;
    $changed(st.prog) |-> $past(in_commit);
  endproperty
  a_prog_only_commit: assert property (p_prog_only_commit)
    else $error("specific data changed outside programming");

  property p_perm_once;
    st.locked[1] |=> $stable(st.prog[`SPEC_PERM_BIT]);
  endproperty
  a_perm_once: assert property (p_perm_once)
    else $error("write-once field rewritten");

  property p_spec_fixed;
    spec_word[127:120] == 8'h90 && spec_word[75:74] == 2'h0 &&
    spec_word[20:17] == 4'h0 && spec_word[0];
  endproperty
  a_spec_fixed: assert property (p_spec_fixed)
    else $error("specific data fixed bits wrong");

  property p_msb_first;
    (take_cmd && cmd.index == `CMD_READ_SPECIFIC)
      |=> (line_oe && line_out == $past(spec_msb));
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("response did not start at the top bit");

  c_busy_poll: cover property (take_cmd && !st.ready);
  c_lost: cover property ($rose(tx_lost));
  c_commit: cover property (prog_done && !prog_error);
  c_reject: cover property ($rose(prog_error));
endmodule : card_register_set

// ### verilog/card_regs_defines.svh
// Constants for the card register set: command codes, fields, defaults
// Assumes one 20 MHz system clock; fields are sent most significant first
// How it works
// - Conditions word is 32 bits, its reserved ranges always read zero
// - Bits 23..15 are one; bit 7 is one only on the dual-voltage build
// - Top conditions bit stays low until power-up ends, then goes high
// - A busy card drives its busy bit low on the shared open-drain line
// - Registers are reached only through their own commands
// - Identity is 128 bits: maker code on top, then 16-bit OEM code
// - Product name sits in bits 103..56 as six ASCII characters
// - Revision byte holds major digit high nibble, minor digit low nibble
// - Serial number is a 32-bit unsigned integer in bits 47..16
// - Date byte holds month (1 is January) high, year from 1997 low
// - Identity bits 7..1 hold a CRC7 of the contents, bit 0 reads one
// - Each card returns its own identity, set here by a serial strap
// - Only programmable specific-data fields change, only by CMD27
// - Read-only fields fixed, write-once fields take one write, others many
// - Specific data is 128 bits: structure version, then spec version
// - Multi-bit fields are unsigned binary, leftmost bit most significant
// - Every card holds the conditions word and returns it on request
// - Structure version code 2 marks version 1.2
`ifndef CARD_REGS_DEFINES_SVH
`define CARD_REGS_DEFINES_SVH
`define SYS_CLK_PERIOD_NS    50
`define POWERUP_TIME_US      1000
`define CMD_READ_CONDITIONS  6'h01
`define CMD_ALL_IDENTITY     6'h02
`define CMD_READ_SPECIFIC    6'h09
`define CMD_READ_IDENTITY    6'h0A
`define CMD_PROGRAM_SPECIFIC 6'h1B
`define WORD_BITS            8'h80
`define COND_BITS            8'h20
`define LAST_RX_BIT          8'h7F
`define COND_VOLT_RANGE      9'h1FF
`define CRC7_POLY            7'h09
`define SPEC_STRUCTURE_VAL   2'h2
`define SPEC_VERSION_VAL     4'h4
`define SPEC_ACCESS_TIME     8'h26
`define SPEC_CLOCK_ACCESS    8'h01
`define SPEC_TRAN_SPEED      8'h2A
`define SPEC_CLASSES         12'h0F5
`define SPEC_BLOCK_LEN       4'h9
`define SPEC_CURR_MIN        3'h6
`define SPEC_PROG_RESET      16'h0001
`define SPEC_FMT_GRP_BIT     15
`define SPEC_COPY_BIT        14
`define SPEC_PERM_BIT        13
`define SPEC_TMP_BIT         12
`endif

// ### verilog/card_regs_pkg.sv
// Types shared by the card register set modules
// Assumes the constants header is compiled alongside
package card_regs_pkg;
  typedef enum logic [1:0] {PH_IDLE, PH_SEND, PH_RECV, PH_COMMIT} phase_type;
  typedef struct packed {
    logic       valid;
    logic [5:0] index;
  } cmd_req_type;
  typedef struct packed {
    logic valid;
    logic data;
  } prog_bit_type;
  typedef struct packed {
    phase_type    phase;
    logic [15:0]  pcnt;
    logic         ready;
    logic         strap_taken;
    logic [31:0]  serial;
    logic [15:0]  prog;
    logic [3:0]   locked;
    logic [127:0] rx;
    logic [7:0]   rx_cnt;
    logic         prog_done;
    logic         prog_error;
  } regs_state_type;
  typedef struct packed {
    logic [127:0] sh;
    logic [7:0]   left;
    logic         od;
    logic         line_out;
    logic         line_oe;
    logic         lost;
  } shift_state_type;
endpackage : card_regs_pkg

// ### verilog/card_crc7.sv
// CRC7 over a 120-bit field, most significant bit first
// Assumes a purely combinational use
`include "card_regs_defines.svh"
module card_crc7 (
  // Data
  input  wire logic [119:0] data,
  // Checksum
  output logic      [6:0]   crc
);
  logic [6:0] chain [0:120];

  assign chain[0] = 7'h00;
  genvar i;
  generate
    for (i = 0; i < 120; i = i + 1)
    begin : g_step
      logic fb;
      assign fb = data[119 - i] ^ chain[i][6];
      assign chain[i + 1] = {chain[i][5:0], 1'b0} ^ (fb ? `CRC7_POLY : 7'h00);
    end
  endgenerate
  assign crc = chain[120];
endmodule : card_crc7

// ### verilog/card_shifter.sv
// Serialises a response word onto the command line, top bit first
// Assumes the line is sampled on the same clock; clk_en freezes it
module card_shifter (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  input  wire logic         clk_en,
  // Load
  input  wire logic         start,
  input  wire logic [127:0] word,
  input  wire logic [7:0]   len,
  input  wire logic         od,
  // Line
  input  wire logic         line_in,
  output logic              line_out,
  output logic              line_oe,
  // Status
  output logic              active,
  output logic              lost
);
  card_regs_pkg::shift_state_type st;
  card_regs_pkg::shift_state_type nxt;
  logic                           bit_now;

  always_comb
  begin
    nxt = st;
    bit_now = 1'b0;
    if (clk_en)
    begin
      if (start)
      begin
        nxt.sh = word;
        nxt.left = len;
        nxt.od = od;
        nxt.lost = 1'b0;
        bit_now = word[127];
        nxt.line_oe = od ? !bit_now : 1'b1;
        nxt.line_out = od ? 1'b0 : bit_now;
      end
      else if (st.left != 8'h00)
      begin
        if (st.od && st.sh[127] && !line_in)
        begin
          nxt.lost = 1'b1;
          nxt.left = 8'h00;
          nxt.line_oe = 1'b0;
          nxt.line_out = 1'b0;
        end
        else
        begin
          nxt.sh = {st.sh[126:0], 1'b0};
          nxt.left = st.left - 8'h01;
          bit_now = st.sh[126];
          nxt.line_oe = (nxt.left == 8'h00) ? 1'b0 :
                        (st.od ? !bit_now : 1'b1);
          nxt.line_out = (st.od || nxt.left == 8'h00) ? 1'b0 : bit_now;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      st <= '0;
    else
      st <= nxt;
  end

  assign line_out = st.line_out;
  assign line_oe  = st.line_oe;
  assign active   = (st.left != 8'h00);
  assign lost     = st.lost;
endmodule : card_shifter

// ### testbench/card_host_model.sv
// Host side of the card line: commands, program words, line capture
// Assumes a pulled-up shared line and an optional rival card pulling low
module card_host_model (
  // Clock
  input  wire logic                   sys_clk,
  // Card line
  input  wire logic                   line_out,
  input  wire logic                   line_oe,
  output logic                        line_in,
  // Requests
  output card_regs_pkg::cmd_req_type  cmd,
  output card_regs_pkg::prog_bit_type prog
);
  timeunit 1ns;
  timeprecision 1ns;
  logic rival_low;
  initial
  begin
    rival_low = 1'b0;
    cmd = '0;
    prog = '0;
  end
  // Pull-up, wired-AND with the rival card
  assign line_in = (line_oe ? line_out : 1'b1) & ~rival_low;
  task automatic send_cmd(input logic [5:0] idx);
    @(posedge sys_clk);
    cmd <= '{valid: 1'b1, index: idx};
    @(posedge sys_clk);
    cmd <= '0;
  endtask : send_cmd
  task automatic capture(input int n, output logic [127:0] w,
                         output int oe);
    w = '0;
    oe = 0;
    repeat (n)
    begin
      @(negedge sys_clk);
      w = {w[126:0], line_in};
      oe += int'(line_oe);
      @(posedge sys_clk);
    end
  endtask : capture
  task automatic write_specific(input logic [127:0] w);
    send_cmd(6'h1B);
    for (int i = 127; i >= 0; i--)
    begin
      prog <= '{valid: 1'b1, data: w[i]};
      @(posedge sys_clk);
    end
    prog <= '0;
  endtask : write_specific
endmodule : card_host_model

// ### testbench/tb.sv
// Testbench for the card register set: reads, arbitration, programming
// Assumes the package, the design and the host model are compiled first
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0]  MAKER  = 8'h27;  // Arbitrary value
  localparam logic [15:0] OEM    = 16'h3C5A; // Arbitrary value
  localparam logic [47:0] NAME   = 48'h544553544344;
  localparam logic [31:0] SERIAL = 32'h8C3157E2;
  localparam logic [7:0]  REV    = 8'h62;
  localparam logic [7:0]  DATE   = 8'h43;
  localparam logic [11:0] DSIZE  = 12'h7FF;
  localparam logic [2:0]  MULT   = 3'h3;
  localparam logic [2:0]  CTOP   = 3'h7;
  logic                        sys_clk;
  logic                        clk_en;
  logic                        resetn;
  logic                        line_in;
  logic                        line_out;
  logic                        line_oe;
  logic                        power_ready;
  logic                        prog_done;
  logic                        prog_error;
  card_regs_pkg::cmd_req_type  cmd;
  card_regs_pkg::prog_bit_type prog;
  int                          mismatches;
  int                          comparisons;

  card_register_set #(
    .MAKER_CODE(MAKER), .OEM_CODE(OEM), .PRODUCT_NAME(NAME),
    .PRODUCT_REV(REV), .MAKE_DATE(DATE), .DEVICE_SIZE(DSIZE),
    .SIZE_MULT(MULT), .CURR_MAX(CTOP), .GROUP_SIZES(15'h1234),
    .WRITE_FACTOR(3'h2), .CONTENT_PROT(1'b1), .POWERUP_CYCLES(60)
  ) dut_u (
    .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .cmd(cmd),
    .prog(prog), .serial_strap(SERIAL), .line_in(line_in),
    .line_out(line_out), .line_oe(line_oe), .power_ready(power_ready),
    .prog_done(prog_done), .prog_error(prog_error)
  );
  card_host_model host_u (
    .sys_clk(sys_clk), .line_out(line_out), .line_oe(line_oe),
    .line_in(line_in), .cmd(cmd), .prog(prog)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic check(input string name, input logic [127:0] seen,
                       input logic [127:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  function automatic logic [6:0] crc7(input logic [119:0] d);
    logic [6:0] c;
    logic       fb;
    c = '0;
    for (int i = 119; i >= 0; i--)
    begin
      fb = d[i] ^ c[6];
      c = {c[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
    end
    return c;
  endfunction : crc7

  // Issue a command, capture n line bits, compare word and drive count
  task automatic read_reg(input logic [5:0] idx, input int n,
                          input string name, input logic [127:0] exp,
                          input int oe_exp);
    logic [127:0] w;
    int           oe;
    host_u.send_cmd(idx);
    host_u.capture(n, w, oe);
    check(name, w, exp);
    check(name, 128'(oe), 128'(oe_exp));
  endtask : read_reg

  // Program a word, then judge the done pulse and the error flag
  task automatic prog_word(input logic [127:0] w, input logic err);
    logic [3:0] seen;
    host_u.write_specific(w);
    for (int k = 0; k < 4; k++)
    begin
      @(negedge sys_clk);
      seen[k] = prog_done;
      @(posedge sys_clk);
    end
    check("done_pulse", 128'(seen), 128'h2);
    check("prog_error", 128'(prog_error), 128'(err));
  endtask : prog_word

  task automatic test_powerup();
    logic [127:0] cond;
    cond = {96'h0, 1'b0, 7'h00, 9'h1FF, 7'h00, 1'b1, 7'h00};
    read_reg(6'h09, 4, "busy_refuse", 128'hF, 0);
    read_reg(6'h01, 32, "cond_busy", cond, 32 - $countones(cond));
    check("ready_early", 128'(power_ready), 128'h0);
    for (int i = 0; i < 100 && power_ready !== 1'b1; i++)
      @(posedge sys_clk);
    check("ready", 128'(power_ready), 128'h1);
    clk_en <= 1'b0;
    read_reg(6'h01, 4, "frozen", 128'hF, 0);
    clk_en <= 1'b1;
    cond[31] = 1'b1;
    read_reg(6'h01, 32, "cond", cond, 32 - $countones(cond));
    $display("test_powerup done");
  endtask : test_powerup

  task automatic test_identity();
    logic [127:0] ident;
    ident = {MAKER, OEM, NAME, REV, SERIAL, DATE, 8'h01};
    ident[7:1] = crc7(ident[127:8]);
    read_reg(6'h0A, 128, "ident_pp", ident, 128);
    read_reg(6'h02, 128, "ident_od", ident, 128 - $countones(ident));
    host_u.rival_low <= 1'b1;
    read_reg(6'h02, 130, "ident_lost", 128'h0, 2);
    host_u.rival_low <= 1'b0;
    read_reg(6'h05, 8, "unmapped", 128'hFF, 0);
    $display("test_identity done");
  endtask : test_identity

  task automatic test_program();
    logic [127:0] spec;
    logic [127:0] w;
    spec = {2'h2, 4'h4, 2'h0, 8'h26, 8'h01, 8'h2A, 12'h0F5, 4'h9, 4'h0,
            2'h0, DSIZE, 3'h6, CTOP, 3'h6, CTOP, MULT, 15'h1234, 1'b1,
            2'h0, 3'h2, 4'h9, 1'b0, 4'h0, 1'b1, 16'h0001};
    read_reg(6'h09, 128, "spec_reset", spec, 128);
    w = spec;
    w[121:120] = 2'h3;
    w[15:0] = {4'b1101, 2'h2, 2'h1, 7'h55, 1'b0};
    prog_word(w, 1'b0);
    spec[15:0] = {w[15:1], 1'b1};
    read_reg(6'h09, 128, "spec_first", spec, 128);
    w = spec;
    w[15:0] = {4'b0010, 2'h1, 2'h3, 7'h2A, 1'b1};
    prog_word(w, 1'b0);
    spec[12] = 1'b0;
    spec[9:1] = {2'h3, 7'h2A};
    read_reg(6'h09, 128, "spec_second", spec, 128);
    w = spec;
    w[100] = ~w[100];
    w[12] = 1'b1;
    prog_word(w, 1'b1);
    read_reg(6'h09, 128, "spec_refused", spec, 128);
    prog_word(spec, 1'b0);
    $display("test_program done");
  endtask : test_program

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  initial
  begin
    mismatches = 0;
    comparisons = 0;
    clk_en = 1'b1;
    resetn = 1'b0;
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    test_powerup();
    test_identity();
    test_program();
    report_and_stop();
  end

  initial
  begin
    #400000;
    mismatches++;
    report_and_stop();
  end
endmodule : tb
